/* File: rtl/dsa_defs.svh */
// constants of the strobe and address block
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH

// ----------------------------------------------------------------
// address organisation
// ----------------------------------------------------------------
`define DSA_BANKS       8
`define DSA_BANK_BITS   3
`define DSA_ROW_BITS    13
`define DSA_COL_BITS    10
`define DSA_DQ_BITS     16
`define DSA_LANES       2
`define DSA_PAGE_BYTES  (((1 << `DSA_COL_BITS) * `DSA_DQ_BITS) / 8)

// ----------------------------------------------------------------
// address bits with a second meaning
// ----------------------------------------------------------------
`define DSA_BIT_AUTO_PRE   10
`define DSA_BIT_BURST_CHOP 12
`define DSA_BIT_TERM_EN    11
`define DSA_MR_EXTENDED    3'h1

// ----------------------------------------------------------------
// command codes {select, row, column, write}, all active low
// ----------------------------------------------------------------
`define DSA_CMD_ACT   4'h3
`define DSA_CMD_READ  4'h5
`define DSA_CMD_WRITE 4'h4
`define DSA_CMD_PRE   4'h2
`define DSA_CMD_MRS   4'h0

// ----------------------------------------------------------------
// burst lengths and buffering
// ----------------------------------------------------------------
`define DSA_BL8        4'h8
`define DSA_BC4        4'h4
`define DSA_FIFO_DEPTH 16
`define DSA_FIFO_WIDTH 18

`endif

/* File: rtl/dsa_fifo.sv */
// write-data buffer with a registered output stage
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"

module dsa_fifo
  import dsa_pkg::*;
#(
  parameter int WIDTH = `DSA_FIFO_WIDTH,
  parameter int DEPTH = `DSA_FIFO_DEPTH
) (
  // system
  input  wire logic  clk,
  input  wire logic  rstn,
  // streams
  dsa_stream_if.snk  inS,
  dsa_stream_if.src  outS
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic [WIDTH-1:0]            outData;
    logic                        outValid;
  } dsa_fifo_state_t;

  dsa_fifo_state_t st_r;
  dsa_fifo_state_t st_nxt;
  logic            inReady;
  logic            doPush;
  logic            doPop;

  // ----------------------------------------------------------------
  // next state: pointers wrap because the depth is a power of two
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    inReady = (st_r.count < (AW+1)'(DEPTH));
    doPush  = inS.valid && inReady;
    doPop   = (st_r.count != '0) && (!st_r.outValid || outS.ready);
    if (doPush) begin
      st_nxt.mem[st_r.wrPtr] = inS.data;
      st_nxt.wrPtr           = st_r.wrPtr + 1'b1;
    end
    if (doPop) begin
      st_nxt.outData  = st_r.mem[st_r.rdPtr];
      st_nxt.outValid = 1'b1;
      st_nxt.rdPtr    = st_r.rdPtr + 1'b1;
    end else if (outS.ready) begin
      st_nxt.outValid = 1'b0;
    end
    if (doPush && !doPop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (doPop && !doPush) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // stream ports
  assign inS.ready  = inReady;
  assign outS.data  = st_r.outData;
  assign outS.valid = st_r.outValid;

endmodule : dsa_fifo

`default_nettype wire

/* File: rtl/dsa_pkg.sv */
// types shared by the strobe and address block
`include "dsa_defs.svh"

package dsa_pkg;

  // ----------------------------------------------------------------
  // transfer phase
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} dsa_phase_t;

  // ----------------------------------------------------------------
  // every pin sampled from the controller, in one bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       linkClk;
    logic                       resetN;
    logic [3:0]                 cmdN;
    logic [`DSA_BANK_BITS-1:0]  bankSelect;
    logic [`DSA_ROW_BITS-1:0]   addr;
    logic                       odt;
    logic [`DSA_DQ_BITS-1:0]    dq;
    logic [`DSA_LANES-1:0]      strobeT;
    logic [`DSA_LANES-1:0]      strobeC;
    logic [`DSA_LANES-1:0]      writeMask;
  } dsa_pins_t;

  // ----------------------------------------------------------------
  // whole state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    dsa_pins_t                                   syncA;
    dsa_pins_t                                   syncB;
    logic                                        linkPrev;
    logic [`DSA_LANES-1:0]                       strobePrevT;
    logic [`DSA_LANES-1:0]                       strobePrevV;
    dsa_phase_t                                  phase;
    logic [3:0]                                  beatsLeft;
    logic                                        autoPre;
    logic [`DSA_BANK_BITS-1:0]                   bank;
    logic [`DSA_BANKS-1:0]                       pageOpen;
    logic [`DSA_BANKS-1:0][`DSA_ROW_BITS-1:0]    openRow;
    logic [`DSA_ROW_BITS-1:0]                    extMode;
    logic [`DSA_DQ_BITS-1:0]                     dqOut;
    logic                                        dqOe;
    logic [`DSA_LANES-1:0]                       strobeOutT;
    logic [`DSA_LANES-1:0]                       strobeOutC;
    logic                                        strobeOe;
    logic                                        termOdt;
    logic                                        rdReady;
    logic                                        push;
    logic [`DSA_FIFO_WIDTH-1:0]                  pushData;
    logic                                        overflow;
    logic                                        bstStart;
    logic                                        bstWrite;
    logic                                        bstChop;
    logic [`DSA_ROW_BITS-1:0]                    bstRow;
    logic [`DSA_COL_BITS-1:0]                    bstCol;
  } dsa_state_t;

endpackage : dsa_pkg

/* File: rtl/dsa_stream_if.sv */
// valid/ready stream carrier between the block and its buffer
`timescale 1ns/1ps
`default_nettype none

interface dsa_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dsa_stream_if

`default_nettype wire

/* File: rtl/dsa_strobe_addr.sv */
// strobe alignment, address decode and page tracking of the memory die
//
// Functional notes
// - memory reset pin low forces reset; operation only while it is high
// - device drives strobes on reads, controller drives them on writes
// - read strobe edges coincide with data changes; write strobes centred
// - every strobe is a true/complement pair; single-ended is unsupported
// - termination enable bit set: termination strobe gets strobe termination
// - termination enable bit clear: shared pin is the write mask
// - activate opens one page per bank; page is 2KB on this part
// - bit 10: auto precharge on read/write, all banks on precharge
// - bit 12 on read/write: low chops burst to four, high gives eight
// - bank bits pick the bank, or the mode register on mode set
`timescale 1ns/1ps
`default_nettype none

module dsa_strobe_addr
  import dsa_pkg::*;
(
  // system
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // command and address pins
  input  wire logic                        linkClk,
  input  wire logic                        resetPinN,
  input  wire logic                        csN,
  input  wire logic                        rasN,
  input  wire logic                        casN,
  input  wire logic                        weN,
  input  wire logic [`DSA_BANK_BITS-1:0]   bankSelect,
  input  wire logic [`DSA_ROW_BITS-1:0]    addr,
  input  wire logic                        odt,
  // data and strobe pins, lane 0 lower byte, lane 1 upper byte
  input  wire logic [`DSA_DQ_BITS-1:0]     dqIn,
  output var  logic [`DSA_DQ_BITS-1:0]     dqOut,
  output var  logic                        dqOe,
  input  wire logic [`DSA_LANES-1:0]       byteStrobeIn,
  input  wire logic [`DSA_LANES-1:0]       byteStrobeCompIn,
  output var  logic [`DSA_LANES-1:0]       byteStrobeOut,
  output var  logic [`DSA_LANES-1:0]       byteStrobeCompOut,
  output var  logic                        byteStrobeOe,
  input  wire logic [`DSA_LANES-1:0]       writeMaskPin,
  output var  logic                        terminationStrobeOdt,
  // write data toward the array: {mask, data}
  output var  logic [`DSA_FIFO_WIDTH-1:0]  arrData,
  output var  logic                        arrValid,
  input  wire logic                        arrReady,
  // read data from the array
  input  wire logic [`DSA_DQ_BITS-1:0]     rdData,
  input  wire logic                        rdValid,
  output var  logic                        rdReady,
  // burst descriptor and status
  output var  logic                        bstStart,
  output var  logic                        bstWrite,
  output var  logic                        bstChop,
  output var  logic                        bstAutoPre,
  output var  logic [`DSA_BANK_BITS-1:0]   bstBank,
  output var  logic [`DSA_ROW_BITS-1:0]    bstRow,
  output var  logic [`DSA_COL_BITS-1:0]    bstCol,
  output var  logic [`DSA_BANKS-1:0]       pageOpen,
  output var  logic                        terminationStrobeEnable,
  output var  logic                        writeOverflow
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dsa_state_t             st_r;
  dsa_state_t             st_nxt;
  dsa_pins_t              pinsIn;
  logic [`DSA_LANES-1:0]  laneValid;
  logic [`DSA_LANES-1:0]  laneEdge;
  logic                   linkRise;
  logic                   linkEdge;
  logic                   cmdAct;
  logic                   cmdRead;
  logic                   cmdWrite;
  logic                   cmdPre;
  logic                   cmdMrs;
  logic                   termEn;

  dsa_stream_if #(.WIDTH(`DSA_FIFO_WIDTH)) pushIf ();
  dsa_stream_if #(.WIDTH(`DSA_FIFO_WIDTH)) popIf ();

  // command match on the synchronised pins, gated by a live rising edge
  function automatic logic isCmd(input dsa_pins_t p, input logic rise, input logic [3:0] code);
    isCmd = rise && p.resetN && (p.cmdN == code);
  endfunction : isCmd

  // close one bank's page when asked
  function automatic logic [`DSA_BANKS-1:0] closeBank(input logic [`DSA_BANKS-1:0] open,
                                                      input logic [`DSA_BANK_BITS-1:0] b,
                                                      input logic doIt);
    closeBank = open;
    if (doIt) begin
      closeBank[b] = 1'b0;
    end
  endfunction : closeBank

  // ----------------------------------------------------------------
  // pin bundle and decode on the second synchroniser stage
  // ----------------------------------------------------------------
  assign pinsIn = '{linkClk: linkClk, resetN: resetPinN, cmdN: {csN, rasN, casN, weN},
                    bankSelect: bankSelect, addr: addr, odt: odt, dq: dqIn,
                    strobeT: byteStrobeIn, strobeC: byteStrobeCompIn,
                    writeMask: writeMaskPin};
  assign linkRise = st_r.syncB.linkClk && !st_r.linkPrev;
  assign linkEdge = st_r.syncB.linkClk != st_r.linkPrev;
  assign cmdAct   = isCmd(st_r.syncB, linkRise, `DSA_CMD_ACT);
  assign cmdRead  = isCmd(st_r.syncB, linkRise, `DSA_CMD_READ);
  assign cmdWrite = isCmd(st_r.syncB, linkRise, `DSA_CMD_WRITE);
  assign cmdPre   = isCmd(st_r.syncB, linkRise, `DSA_CMD_PRE);
  assign cmdMrs   = isCmd(st_r.syncB, linkRise, `DSA_CMD_MRS);
  assign termEn   = st_r.extMode[`DSA_BIT_TERM_EN];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.syncA    = pinsIn;
    st_nxt.syncB    = st_r.syncA;
    st_nxt.linkPrev = st_r.syncB.linkClk;
    st_nxt.push     = 1'b0;
    st_nxt.rdReady  = 1'b0;
    st_nxt.bstStart = 1'b0;

    // a lane edge counts only while the pair is complementary
    laneValid = st_r.syncB.strobeT ^ st_r.syncB.strobeC;
    laneEdge  = laneValid & st_r.strobePrevV & (st_r.syncB.strobeT ^ st_r.strobePrevT);
    st_nxt.strobePrevT = st_r.syncB.strobeT;
    st_nxt.strobePrevV = laneValid;

    // termination pair follows strobe termination only when enabled
    st_nxt.termOdt = termEn && st_r.syncB.odt;

    // activate: open one page in the selected bank
    if (cmdAct) begin
      st_nxt.pageOpen[st_r.syncB.bankSelect] = 1'b1;
      st_nxt.openRow[st_r.syncB.bankSelect]  = st_r.syncB.addr;
    end

    // precharge: one bank or all banks
    if (cmdPre) begin
      if (st_r.syncB.addr[`DSA_BIT_AUTO_PRE]) begin
        st_nxt.pageOpen = '0;
      end else begin
        st_nxt.pageOpen = closeBank(st_r.pageOpen, st_r.syncB.bankSelect, 1'b1);
      end
    end

    // mode set: the bank bits name the register
    if (cmdMrs && st_r.syncB.bankSelect == `DSA_MR_EXTENDED) begin
      st_nxt.extMode = st_r.syncB.addr;
    end

    // a new burst is only taken while idle
    if ((cmdRead || cmdWrite) && st_r.phase == PH_IDLE) begin
      st_nxt.beatsLeft = st_r.syncB.addr[`DSA_BIT_BURST_CHOP] ? `DSA_BL8 : `DSA_BC4;
      st_nxt.autoPre   = st_r.syncB.addr[`DSA_BIT_AUTO_PRE];
      st_nxt.bank      = st_r.syncB.bankSelect;
      st_nxt.bstStart  = 1'b1;
      st_nxt.bstWrite  = cmdWrite;
      st_nxt.bstChop   = !st_r.syncB.addr[`DSA_BIT_BURST_CHOP];
      st_nxt.bstRow    = st_r.openRow[st_r.syncB.bankSelect];
      st_nxt.bstCol    = st_r.syncB.addr[`DSA_COL_BITS-1:0];
      if (cmdRead) begin
        // preamble: pair driven low/high before the first beat
        st_nxt.phase      = PH_READ;
        st_nxt.strobeOe   = 1'b1;
        st_nxt.dqOe       = 1'b1;
        st_nxt.strobeOutT = '0;
        st_nxt.strobeOutC = '1;
      end else begin
        st_nxt.phase = PH_WRITE;
      end
    end

    unique case (st_r.phase)
      PH_IDLE: begin
      end
      PH_WRITE: begin
        // both lanes are launched together, so one word per joint edge
        if (&laneEdge) begin
          if (pushIf.ready && !st_r.push) begin
            st_nxt.push     = 1'b1;
            st_nxt.pushData = {termEn ? {`DSA_LANES{1'b0}} : st_r.syncB.writeMask,
                               st_r.syncB.dq};
          end else begin
            st_nxt.overflow = 1'b1;
          end
          st_nxt.beatsLeft = st_r.beatsLeft - 1'b1;
          if (st_r.beatsLeft == 4'h1) begin
            st_nxt.phase    = PH_IDLE;
            st_nxt.pageOpen = closeBank(st_nxt.pageOpen, st_r.bank, st_r.autoPre);
          end
        end
      end
      PH_READ: begin
        if (st_r.rdReady) begin
          // data and strobe leave the same flop edge, so edges line up
          st_nxt.dqOut      = rdValid ? rdData : st_r.dqOut;
          st_nxt.strobeOutT = ~st_r.strobeOutT;
          st_nxt.strobeOutC = ~st_r.strobeOutC;
          st_nxt.beatsLeft  = st_r.beatsLeft - 1'b1;
        end else if (linkEdge) begin
          if (st_r.beatsLeft != 4'h0) begin
            st_nxt.rdReady = 1'b1;
          end else begin
            // postamble over: hand the strobe back to the controller
            st_nxt.phase    = PH_IDLE;
            st_nxt.strobeOe = 1'b0;
            st_nxt.dqOe     = 1'b0;
            st_nxt.pageOpen = closeBank(st_nxt.pageOpen, st_r.bank, st_r.autoPre);
          end
        end
      end
    endcase

    // pin reset wipes everything but the synchronisers themselves
    if (!st_r.syncB.resetN) begin
      st_nxt          = '0;
      st_nxt.syncA    = pinsIn;
      st_nxt.syncB    = st_r.syncA;
      st_nxt.linkPrev = st_r.syncB.linkClk;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // write-data buffer; full drops beats and raises the overflow flag
  // ----------------------------------------------------------------
  assign pushIf.data  = st_r.pushData;
  assign pushIf.valid = st_r.push;
  assign popIf.ready  = arrReady;

  dsa_fifo #(.WIDTH(`DSA_FIFO_WIDTH), .DEPTH(`DSA_FIFO_DEPTH)) u_fifo (
    .clk  (clk),
    .rstn (rstn),
    .inS  (pushIf.snk),
    .outS (popIf.src)
  );

  // outputs, all flops
  assign arrData                 = popIf.data;
  assign arrValid                = popIf.valid;
  assign dqOut                   = st_r.dqOut;
  assign dqOe                    = st_r.dqOe;
  assign byteStrobeOut           = st_r.strobeOutT;
  assign byteStrobeCompOut       = st_r.strobeOutC;
  assign byteStrobeOe            = st_r.strobeOe;
  assign terminationStrobeOdt    = st_r.termOdt;
  assign rdReady                 = st_r.rdReady;
  assign bstStart                = st_r.bstStart;
  assign bstWrite                = st_r.bstWrite;
  assign bstChop                 = st_r.bstChop;
  assign bstAutoPre              = st_r.autoPre;
  assign bstBank                 = st_r.bank;
  assign bstRow                  = st_r.bstRow;
  assign bstCol                  = st_r.bstCol;
  assign pageOpen                = st_r.pageOpen;
  assign terminationStrobeEnable = termEn;
  assign writeOverflow           = st_r.overflow;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_readCmd;
    cmdRead && st_r.phase == PH_IDLE;
  endsequence

  sequence s_preamble;
    st_r.strobeOe && st_r.strobeOutT == 2'b00 && st_r.strobeOutC == 2'b11;
  endsequence

  property p_pinReset;
    !st_r.syncB.resetN |=> st_r.pageOpen == '0 && !st_r.strobeOe && st_r.phase == PH_IDLE;
  endproperty
  a_pinReset: assert property (p_pinReset) else $error("pin reset did not clear state");

  property p_writeNoDrive;
    st_r.phase == PH_WRITE |-> !st_r.strobeOe && !st_r.dqOe;
  endproperty
  a_writeNoDrive: assert property (p_writeNoDrive) else $error("strobe driven in write");

  property p_readPreamble;
    s_readCmd ##1 st_r.syncB.resetN |-> s_preamble;
  endproperty
  a_readPreamble: assert property (p_readPreamble) else $error("no read preamble");

  property p_edgeAlign;
    st_r.dqOe && $changed(st_r.dqOut) |-> $changed(st_r.strobeOutT);
  endproperty
  a_edgeAlign: assert property (p_edgeAlign) else $error("data moved without strobe");

  property p_diffPair;
    st_r.strobeOe |-> st_r.strobeOutT == ~st_r.strobeOutC;
  endproperty
  a_diffPair: assert property (p_diffPair) else $error("strobe pair not complementary");

  property p_termOn;
    termEn && st_r.syncB.odt && st_r.syncB.resetN |=> st_r.termOdt;
  endproperty
  a_termOn: assert property (p_termOn) else $error("termination pair not terminated");

  property p_maskOff;
    st_r.push && $past(termEn) |-> st_r.pushData[`DSA_FIFO_WIDTH-1 -: `DSA_LANES] == '0
                                   && st_r.termOdt == $past(st_r.syncB.odt);
  endproperty
  a_maskOff: assert property (p_maskOff) else $error("mask used while termination on");

  property p_activate;
    cmdAct |=> st_r.pageOpen[$past(st_r.syncB.bankSelect)]
               && st_r.openRow[$past(st_r.syncB.bankSelect)] == $past(st_r.syncB.addr);
  endproperty
  a_activate: assert property (p_activate) else $error("activate did not open page");

  property p_preAll;
    cmdPre && st_r.syncB.addr[`DSA_BIT_AUTO_PRE] |=> st_r.pageOpen == '0;
  endproperty
  a_preAll: assert property (p_preAll) else $error("precharge all left a page open");

  property p_chop;
    s_readCmd and !st_r.syncB.addr[`DSA_BIT_BURST_CHOP] |=> st_r.beatsLeft == `DSA_BC4 && bstChop;
  endproperty
  a_chop: assert property (p_chop) else $error("chopped burst length wrong");

  property p_modeSet;
    cmdMrs && st_r.syncB.bankSelect == `DSA_MR_EXTENDED |=> st_r.extMode == $past(st_r.syncB.addr);
  endproperty
  a_modeSet: assert property (p_modeSet) else $error("extended mode not written");

endmodule : dsa_strobe_addr

`default_nettype wire

/* File: test/dsa_ctrl_model.sv */
// controller-side model: command pins, link clock and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module dsa_ctrl_model (
  // system
  input  wire logic        clk,
  // command pins
  output var  logic        linkClk,
  output var  logic        resetPinN,
  output var  logic        csN,
  output var  logic        rasN,
  output var  logic        casN,
  output var  logic        weN,
  output var  logic [2:0]  bankSelect,
  output var  logic [12:0] addr,
  output var  logic        odt,
  // data side
  output var  logic [15:0] dqIn,
  output var  logic [1:0]  byteStrobeIn,
  output var  logic [1:0]  byteStrobeCompIn,
  output var  logic [1:0]  writeMaskPin
);
  // ------------------------------------------------------------
  // pin driving
  // ------------------------------------------------------------
  logic [17:0] sent[$];  // words the array side must see, in order

  // reset pin rests high, link clock stands still between frames
  initial begin
    {linkClk, bankSelect, addr, dqIn, writeMaskPin, byteStrobeIn} = '0;
    {csN, rasN, casN, weN} = 4'hf;
    {resetPinN, odt} = 2'h3;
    byteStrobeCompIn = 2'h3;
  end

  // 62.5 ns is 25 clk half periods; only the 1 ns offset in issue keeps link edges clear of clk edges
  task automatic halfLink(input int n);
    repeat (n) #62.5 linkClk = ~linkClk;
  endtask : halfLink

  // code and address held over the rising link edge
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
    @(negedge clk);
    #1 {csN, rasN, casN, weN, bankSelect, addr} = {c, b, a};
    halfLink(2);
    {csN, rasN, casN, weN} = 4'hf;
  endtask : issue

  // strobe pair toggles mid-eye, both lanes together
  task automatic burst(input int n, input logic [15:0] d, input logic [1:0] mk, input logic te);
    repeat (n) begin
      @(negedge clk);
      {dqIn, writeMaskPin} = {d, mk};
      repeat (2) @(negedge clk);
      byteStrobeIn = ~byteStrobeIn;
      byteStrobeCompIn = ~byteStrobeCompIn;
      sent.push_back({te ? 2'h0 : mk, d});
      d = d + 16'h1;
      repeat (2) @(negedge clk);
    end
    dqIn = ~dqIn;  // inverted: no stale value left on the data lines
  endtask : burst

  // pin reset only to start a reset procedure
  task automatic pinReset();
    @(negedge clk);
    resetPinN = 1'b0;
    repeat (8) @(negedge clk);
    resetPinN = 1'b1;
  endtask : pinReset
endmodule : dsa_ctrl_model
`default_nettype wire

/* File: test/test_ddr3_strobe_and_address_map.sv */
// self-checking bench of the strobe and address block
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.svh"
module test_ddr3_strobe_and_address_map;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk = 1'b0, rstn = 1'b0, arrReady = 1'b0, rdValid = 1'b1;
  logic [15:0] rdData = 16'h0, dqIn, dqOut;
  logic [12:0] addr, bstRow;
  logic [2:0]  bankSelect, bstBank;
  logic [1:0]  byteStrobeIn, byteStrobeCompIn, byteStrobeOut, byteStrobeCompOut;
  logic [1:0]  writeMaskPin;
  logic [17:0] arrData;
  logic [9:0]  bstCol;
  logic [7:0]  pageOpen;
  logic        linkClk, resetPinN, csN, rasN, casN, weN, odt, dqOe, byteStrobeOe, arrValid;
  logic        terminationStrobeOdt, rdReady, bstStart, bstWrite, bstChop, bstAutoPre;
  logic        terminationStrobeEnable, writeOverflow;
  int          err_count = 0, checks_done = 0, starts = 0, beats = 0;
  logic [31:0] seed = 32'h11;

  dsa_strobe_addr dut (.*);
  dsa_ctrl_model m (.*);

  always #2.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // array side stalls every other cycle while seed bit 4 is low, never for good
  always @(negedge clk) arrReady <= ~arrReady | seed[4];

  // popped words, driven strobe pairs and burst starts
  always @(posedge clk) begin
    if (arrValid === 1'b1 && arrReady === 1'b1) check("arrData", arrData, m.sent.pop_front());
    if (byteStrobeOe === 1'b1) check("strobe pair", byteStrobeCompOut, 2'(~byteStrobeOut));
    if (bstStart === 1'b1) starts++;
    if (rdReady === 1'b1) beats++;
  end

  initial begin : main
    int          i;
    logic [2:0]  b;
    logic [12:0] row;
    logic [9:0]  col;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    b = 3'(rnd());
    row = 13'(rnd());
    m.issue(`DSA_CMD_ACT, b, row);
    check("pageOpen", pageOpen, 8'h1 << b);
    $display("done: activate");
    // chopped write, then full write with auto precharge
    for (i = 0; i < 2; i++) begin
      m.issue(`DSA_CMD_MRS, `DSA_MR_EXTENDED, 13'(i) << 11);
      check("termEn", terminationStrobeEnable, i);
      check("termOdt", terminationStrobeOdt, i);
      col = 10'(rnd());
      m.issue(`DSA_CMD_WRITE, b, {i[0], 1'b0, i[0], col});
      check("burst", {bstWrite, bstChop, bstAutoPre, bstBank, bstRow, bstCol},
            {1'b1, ~i[0], i[0], b, row, col});
      m.burst(4 + 4 * i, 16'(rnd()), 2'(rnd()), i[0]);
      repeat (8) @(negedge clk);
      check("pageOpen", pageOpen, i ? 8'h0 : 8'h1 << b);
      $display("done: write %0d", i);
    end
    m.issue(`DSA_CMD_ACT, b, row);
    rdData = 16'(rnd());
    m.issue(`DSA_CMD_READ, b, 13'h0);
    check("read drive", {dqOe, byteStrobeOe}, 2'h3);
    m.halfLink(1);
    repeat (6) @(negedge clk);
    check("dqOut", dqOut, rdData);
    m.halfLink(3);
    repeat (6) @(negedge clk);
    check("read release", {dqOe, byteStrobeOe}, 2'h0);
    check("starts", starts, 3);
    check("read beats", beats, 4);
    $display("done: read");
    m.issue(`DSA_CMD_ACT, b ^ 3'h1, row);
    m.issue(`DSA_CMD_PRE, b, 13'h0);
    check("pageOpen", pageOpen, 8'h1 << (b ^ 3'h1));
    m.issue(`DSA_CMD_ACT, b, row);
    m.issue(`DSA_CMD_PRE, b ^ 3'h2, 13'h400);
    check("pageOpen", pageOpen, 8'h0);
    check("overflow", writeOverflow, 1'b0);
    m.issue(`DSA_CMD_ACT, b, row);
    m.pinReset();
    repeat (6) @(negedge clk);
    check("pin reset", {pageOpen, terminationStrobeEnable}, 9'h0);
    for (i = 0; i < 400 && m.sent.size() > 0; i++) @(negedge clk);
    check("drained", m.sent.size(), 0);
    $display("done: precharge and reset");
    conclude();
  end : main
endmodule : test_ddr3_strobe_and_address_map
`default_nettype wire
